// ===== shared/adc_frame_defines.vh
`ifndef ADC_FRAME_DEFINES_VH
`define ADC_FRAME_DEFINES_VH

// Frame layout
`define FRAME_BITS 24
`define FRAME_LAST_FALL 5'h17
`define RESULT_BITS 18
`define TAIL_ZEROS 4'h0
`define FIXED_ZERO_BIT 1'b0

// Result coding
`define RAW_BITS 20
`define RAW_MAX 20'sh10000
`define RAW_MIN -20'sh10001
`define CODE_OFFSET 18'h20000

// Input word
`define IN_WORD_BITS 8
`define IN_LAST_BIT 4'h7
`define IN_DONE 4'h8
`define SEL_ENABLE 3'h5
`define SEL_DEFAULT 5'h00
`define LEAD_HI 7
`define LEAD_LO 5
`define SEL_SGL 4
`define SEL_ODD 3
`define SEL_IDX_HI 2

// Channel defaults
`define POS_DEFAULT 4'h0
`define NEG_DEFAULT 4'h1
`define NEG_ON_COMMON 4'h0

// Result FIFO
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// ===== logic/adc_serial_frame.v
`timescale 1ns/1ps
`include "adc_frame_defines.vh"

module result_fifo #(
  parameter W = `RESULT_BITS,
  parameter D = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire mclk,
  input wire sys_rst,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data = mem[rd_r];

  always @(posedge mclk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // Flags registered so the ready port comes straight from a flop
  always @(posedge mclk) begin
    if (sys_rst) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == D - 1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == D - 1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != D);
      out_valid <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end
endmodule

// Two flops per pin; a third copy gives the edge finder its reference
module pin_sync #(
  parameter INIT = 1'b0
) (
  input wire mclk,
  input wire sys_rst,
  input wire pin,
  output reg sync_r,
  output reg dly_r
);
  reg meta_r;

  // Only the second and third stages are read outside; the first may be metastable
  always @(posedge mclk) begin
    if (sys_rst) begin
      meta_r <= INIT;
      sync_r <= INIT;
      dly_r <= INIT;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      dly_r <= sync_r;
    end
  end
endmodule

// Summary of operation
// - 24-bit frame: flag, zero, sign, result, zeros
// - First bit high while converting, low when done
// - Second bit always driven low
// - Third bit high for positive input
// - Sign and bit 20 flag over/under range
// - Bits 20 to 4 carry result, MSB first
// - Last four bits always low
// - Chip select high: output off, clock ignored
// - Flag shown on select low, falls at completion
// - Bit 22 leaves on first falling edge
// - Bit 0 leaves on 23rd falling edge
// - 24th falling edge drives output high, restarts
// - Out-of-range results clamp one LSB beyond scale
// - Result coded as offset binary pattern
// - Eight-bit input word, five bits pick channel
// - Reset selects channel 0/1, starts conversion
// - Leading 000 or 100 keeps previous channel
// - Leading 101 loads next five selection bits
// - Single-ended flag picks differential pair or common
// - Odd flag and index choose channel, polarity
// - New selection applies to the next conversion
// - Shift out on falling, capture on rising
// - Early chip select rise aborts, restarts conversion
// - Pair n uses 2n, 2n+1; odd swaps
module adc_serial_frame #(
  parameter FRAME_W = `FRAME_BITS,
  parameter RESULT_W = `RESULT_BITS,
  parameter RAW_W = `RAW_BITS,
  parameter IN_W = `IN_WORD_BITS,
  parameter FIFO_D = `FIFO_DEPTH,
  parameter FIFO_AW = `FIFO_AW
) (
  input wire mclk,
  input wire sys_rst,
  input wire cs_n,
  input wire sck,
  input wire sdi,
  output reg sdo_data,
  output reg sdo_oe,
  input wire res_valid,
  output wire res_ready,
  input wire [RAW_W-1:0] res_raw,
  output reg conv_start_r,
  output reg [3:0] pos_ch_r,
  output reg [3:0] neg_ch_r,
  output reg neg_com_r,
  output reg [4:0] sel_r
);
  // Idle and flag act alike; idle only marks a fresh selection
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_FLAG = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  wire cs_s_r;
  wire cs_d_r;
  wire sck_s_r;
  wire sck_d_r;
  wire sdi_s_r;

  reg boot_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [4:0] fcnt_r;
  reg [4:0] fcnt_nxt;
  reg [FRAME_W-1:0] sr_r;
  reg [FRAME_W-1:0] sr_nxt;
  reg sdo_nxt;
  reg sdo_oe_nxt;

  reg [IN_W-1:0] in_sr_r;
  reg [IN_W-1:0] in_sr_nxt;
  reg [3:0] in_cnt_r;
  reg [3:0] in_cnt_nxt;
  reg [4:0] next_sel_r;
  reg [4:0] next_sel_nxt;
  reg [4:0] sel_nxt;
  reg [3:0] pos_ch_nxt;
  reg [3:0] neg_ch_nxt;
  reg neg_com_nxt;
  reg [RAW_W-1:0] clamped;

  wire head_valid;
  wire [RESULT_W-1:0] head_code;
  wire [RESULT_W-1:0] code_in;
  wire reading;
  wire done;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;
  wire frame_end;
  wire abort;
  wire conv_go;
  wire take_bit;
  wire [IN_W-1:0] in_word;

  // Edges compare the second stage against the third
  assign reading = (state_r == ST_SHIFT);
  assign done = (state_r == ST_DONE);
  assign sck_rise = sck_s_r & ~sck_d_r;
  assign sck_fall = ~sck_s_r & sck_d_r;
  assign cs_rise = cs_s_r & ~cs_d_r;
  assign frame_end = ~cs_s_r & reading & sck_fall & (fcnt_r == `FRAME_LAST_FALL);
  assign abort = cs_rise & reading;
  assign conv_go = boot_r | frame_end | abort;
  assign take_bit = ~cs_s_r & sck_rise & (reading | (~done & head_valid));
  assign in_word = {in_sr_r[IN_W-2:0], sdi_s_r};

  // Clamp one LSB past full scale, then offset into offset binary form
  always @* begin
    clamped = res_raw;
    if ($signed(res_raw) > $signed(`RAW_MAX)) begin
      clamped = `RAW_MAX;
    end else if ($signed(res_raw) < $signed(`RAW_MIN)) begin
      clamped = `RAW_MIN;
    end
  end
  assign code_in = clamped[`RESULT_BITS-1:0] + `CODE_OFFSET;

  result_fifo #(
    .W(RESULT_W),
    .D(FIFO_D),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(code_in),
    .out_valid(head_valid),
    .out_ready(frame_end | abort),
    .out_data(head_code)
  );

  // Pins are asynchronous to mclk; edges are found on the second stage
  pin_sync #(
    .INIT(1'b1)
  ) u_cs_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(cs_n),
    .sync_r(cs_s_r),
    .dly_r(cs_d_r)
  );

  // Idle low so reset release shows no false edge
  pin_sync #(
    .INIT(1'b0)
  ) u_sck_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(sck),
    .sync_r(sck_s_r),
    .dly_r(sck_d_r)
  );

  // Data needs no edge finder; its third stage is left open
  pin_sync #(
    .INIT(1'b0)
  ) u_sdi_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(sdi),
    .sync_r(sdi_s_r),
    .dly_r()
  );

  // Output frame
  always @* begin
    state_nxt = state_r;
    fcnt_nxt = fcnt_r;
    sr_nxt = sr_r;
    sdo_nxt = sdo_data;
    sdo_oe_nxt = 1'b1;
    if (cs_s_r) begin
      state_nxt = ST_IDLE;
      fcnt_nxt = 5'h00;
      sdo_nxt = 1'b0;
      sdo_oe_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE, ST_FLAG: begin
          // Live flag; a status poll with no result shifts nothing
          sdo_nxt = ~head_valid;
          state_nxt = ST_FLAG;
          if (sck_rise & head_valid) begin
            state_nxt = ST_SHIFT;
            sr_nxt = {1'b0, `FIXED_ZERO_BIT, head_code, `TAIL_ZEROS};
          end
        end
        ST_SHIFT: begin
          if (sck_fall) begin
            fcnt_nxt = fcnt_r + 5'h01;
            sr_nxt = {sr_r[FRAME_W-2:0], 1'b0};
            if (fcnt_r == `FRAME_LAST_FALL) begin
              sdo_nxt = 1'b1;
              state_nxt = ST_DONE;
            end else begin
              sdo_nxt = sr_r[FRAME_W-2];
            end
          end
        end
        ST_DONE: begin
          sdo_nxt = ~head_valid;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      fcnt_r <= 5'h00;
      sr_r <= {FRAME_W{1'b0}};
      sdo_data <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      fcnt_r <= fcnt_nxt;
      sr_r <= sr_nxt;
      sdo_data <= sdo_nxt;
      sdo_oe <= sdo_oe_nxt;
    end
  end

  // Input word; bits past the eighth fall away
  always @* begin
    in_sr_nxt = in_sr_r;
    in_cnt_nxt = in_cnt_r;
    next_sel_nxt = next_sel_r;
    if (cs_s_r) begin
      in_cnt_nxt = 4'h0;
    end else if (take_bit && in_cnt_r != `IN_DONE) begin
      in_sr_nxt = in_word;
      in_cnt_nxt = in_cnt_r + 4'h1;
      if (in_cnt_r == `IN_LAST_BIT && in_word[`LEAD_HI:`LEAD_LO] == `SEL_ENABLE) begin
        next_sel_nxt = in_word[`SEL_SGL:0];
      end
      // Other leading patterns leave the pending selection alone
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      in_sr_r <= {IN_W{1'b0}};
      in_cnt_r <= 4'h0;
      next_sel_r <= `SEL_DEFAULT;
    end else begin
      in_sr_r <= in_sr_nxt;
      in_cnt_r <= in_cnt_nxt;
      next_sel_r <= next_sel_nxt;
    end
  end

  // Selection lands only with a start, never mid-conversion
  always @* begin
    sel_nxt = sel_r;
    pos_ch_nxt = pos_ch_r;
    neg_ch_nxt = neg_ch_r;
    neg_com_nxt = neg_com_r;
    if (conv_go) begin
      sel_nxt = next_sel_r;
      pos_ch_nxt = {next_sel_r[`SEL_IDX_HI:0], next_sel_r[`SEL_ODD]};
      neg_ch_nxt = next_sel_r[`SEL_SGL] ? `NEG_ON_COMMON :
        {next_sel_r[`SEL_IDX_HI:0], ~next_sel_r[`SEL_ODD]};
      neg_com_nxt = next_sel_r[`SEL_SGL];
    end
  end

  // Conversion start and channel decode
  always @(posedge mclk) begin
    if (sys_rst) begin
      boot_r <= 1'b1;
      conv_start_r <= 1'b0;
      sel_r <= `SEL_DEFAULT;
      pos_ch_r <= `POS_DEFAULT;
      neg_ch_r <= `NEG_DEFAULT;
      neg_com_r <= 1'b0;
    end else begin
      boot_r <= 1'b0;
      conv_start_r <= conv_go;
      sel_r <= sel_nxt;
      pos_ch_r <= pos_ch_nxt;
      neg_ch_r <= neg_ch_nxt;
      neg_com_r <= neg_com_nxt;
    end
  end
endmodule

// ===== testbench/adc_serial_frame_props.sv
`timescale 1ns/1ps
module adc_serial_frame_props (
  input wire mclk,
  input wire sys_rst,
  input wire cs_n,
  input wire sdo_data,
  input wire sdo_oe,
  input wire conv_start_r,
  input wire neg_com_r,
  input wire [3:0] pos_ch_r,
  input wire [3:0] neg_ch_r,
  input wire [4:0] sel_r
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Margin for the pin synchronisers
  sequence s_desel;
    cs_n [*5];
  endsequence
  sequence s_sel;
    !cs_n [*5];
  endsequence
  a_desel_hiz: assert property (s_desel |-> !sdo_oe) else $error("sdo on");
  a_sel_drive: assert property (s_sel |-> sdo_oe) else $error("sdo off");
  a_desel_quiet: assert property (cs_n [*8] |-> !conv_start_r) else $error("start");
  a_start_high: assert property (conv_start_r && !cs_n |-> sdo_data && sdo_oe)
    else $error("sdo low");
  a_start_pulse: assert property (conv_start_r |=> !conv_start_r) else $error("pulse");
  a_sel_hold: assert property (!conv_start_r |->
    $stable({sel_r, pos_ch_r, neg_ch_r, neg_com_r})) else $error("sel moved");
  a_pos_map: assert property (conv_start_r |-> pos_ch_r == {sel_r[2:0], sel_r[3]})
    else $error("pos");
  a_neg_map: assert property (conv_start_r |-> neg_com_r == sel_r[4] &&
    neg_ch_r == (sel_r[4] ? 4'h0 : {sel_r[2:0], ~sel_r[3]})) else $error("neg");
endmodule

// ===== testbench/adc_host_model.sv
`timescale 1ns/1ps
module adc_host_model (
  input wire mclk,
  input wire sdo,
  output reg cs_n = 1'b1,
  output reg sck = 1'b0,
  output reg sdi = 1'b0
);
  task tick;
    repeat (4) @(posedge mclk);
  endtask
  // Fewer than 24 clocks cuts the frame short
  task xfer(input [7:0] w, input integer n, output [23:0] r);
    integer k;
    begin
      r = 24'h0;
      sck <= 1'b1;
      tick;
      sck <= 1'b0;
      tick;
      cs_n <= 1'b0;
      tick;
      tick;
      for (k = 0; k < n; k = k + 1) begin
        sdi <= (k < 8) ? w[7 - k] : ~sdi;
        tick;
        r[23 - k] = sdo;
        sck <= 1'b1;
        tick;
        sck <= 1'b0;
        tick;
      end
      cs_n <= 1'b1;
      tick;
      tick;
    end
  endtask
endmodule

// ===== testbench/adc_serial_frame_tb.sv
`timescale 1ns/1ps
module adc_serial_frame_tb;
  localparam [119:0] CN = {20'h10000, 20'h11170, 20'hEFFFF, 20'hE0000, 20'h0, 20'hFFFFF};
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg res_valid = 1'b0;
  reg [19:0] res_raw = 20'h0;
  wire cs_n, sck, sdi, sdo_data, sdo_oe, res_ready, conv_start_r, neg_com_r;
  wire [3:0] pos_ch_r, neg_ch_r;
  wire [4:0] sel_r;
  wire sdo = sdo_oe ? sdo_data : 1'b1; // Pulled up when released
  wire [23:0] chan = {10'h0, sel_r, pos_ch_r, neg_ch_r, neg_com_r};
  integer num_errors = 0, total_checks = 0, seed = 32'h3D96, cyc = 0, i;
  reg [19:0] raws [0:7];
  reg [23:0] rd;
  reg [7:0] w;
  reg [4:0] sel_x = 5'h0;
  always #25 mclk = ~mclk;
  adc_serial_frame dut_u (.mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .sdo_data(sdo_data), .sdo_oe(sdo_oe), .res_valid(res_valid), .res_ready(res_ready),
    .res_raw(res_raw), .conv_start_r(conv_start_r), .pos_ch_r(pos_ch_r),
    .neg_ch_r(neg_ch_r), .neg_com_r(neg_com_r), .sel_r(sel_r));
  adc_host_model host_u (.mclk(mclk), .sdo(sdo), .cs_n(cs_n), .sck(sck), .sdi(sdi));
  function [23:0] frame_of(input [19:0] r);
    reg signed [19:0] c;
    begin
      c = r;
      if (c > 20'sh10000) c = 20'sh10000;
      if (c < -20'sh10001) c = -20'sh10001;
      frame_of = {2'h0, c[17:0] + 18'h20000, 4'h0};
    end
  endfunction
  function [13:0] dec(input [4:0] s);
    dec = {s, s[2:0], s[3], s[4] ? 5'h01 : {s[2:0], ~s[3], 1'b0}};
  endfunction
  task chk(input [23:0] got, input [23:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Valid stays up between pushes; caller lowers it
  task push(input [19:0] r);
    begin
      res_valid <= 1'b1;
      res_raw <= r;
      @(posedge mclk);
      while (res_ready !== 1'b1) @(posedge mclk);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(chan, 24'h2);
    for (i = 0; i < 8; i = i + 1) begin
      raws[i] = (i < 6) ? CN[i * 20 +: 20] : $random(seed);
      push(raws[i]);
    end
    res_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({23'h0, res_ready}, 24'h0); // Full buffer refuses
    for (i = 0; i < 8; i = i + 1) begin
      w = $random(seed);
      w[7:5] = (i % 3 == 2) ? 3'b101 : {i[0], 2'b00};
      if (w[7:5] == 3'b101) sel_x = w[4:0];
      host_u.xfer(w, 24, rd);
      chk(rd, frame_of(raws[i]));
      chk(chan, {10'h0, dec(sel_x)});
    end
    push(20'h0ABCD);
    push(20'h00123);
    res_valid <= 1'b0;
    host_u.xfer(8'hA1, 6, rd);
    host_u.xfer(8'h00, 24, rd);
    chk(rd, frame_of(20'h00123));
    chk(chan, {10'h0, dec(sel_x)});
    host_u.xfer(8'h00, 24, rd);
    chk(rd, 24'hFFFFFF);
    end_of_test;
  end
endmodule
bind adc_serial_frame adc_serial_frame_props chk_u (.mclk(mclk), .sys_rst(sys_rst),
  .cs_n(cs_n), .sdo_data(sdo_data), .sdo_oe(sdo_oe), .conv_start_r(conv_start_r),
  .neg_com_r(neg_com_r), .pos_ch_r(pos_ch_r), .neg_ch_r(neg_ch_r), .sel_r(sel_r));
